/* File: bench/ir_xcvr_model.sv */
`timescale 1ns/1ns
module ir_xcvr_model (
   input  wire logic       shutdown_in,
   input  wire logic       ir_tx_input,
   input  wire logic       rc_tx_input,
   input  wire logic       light,
   output logic            rx_pin,
   output logic            led,
   output logic [1:0]      mode,
   output logic            timing_err
);
   time  sd_rise_t = 0;
   time  sd_fall_t = 0;
   time  ir_rise_t = 0;
   time  ir_chg_t  = 0;
   logic sd_up     = 1'h0;
   logic fell_once = 1'h0;
   logic ir_up     = 1'h0;
   logic rc_seen   = 1'h0;

   initial begin
      mode       = ir_ctl_pkg::MODE_SIR;
      timing_err = 1'h0;
   end

   assign led    = !shutdown_in && (ir_tx_input ^ rc_tx_input);
   assign rx_pin = shutdown_in ? 1'h1 : light;

   always @(posedge shutdown_in) begin
      if (shutdown_in === 1'h1) begin
         sd_rise_t = $time;
         sd_up     = 1'h1;
         ir_up     = 1'h0;
         rc_seen   = 1'h0;
      end
   end

   always @(ir_tx_input) begin
      if (sd_up) begin
         if ($time - sd_rise_t < ir_ctl_pkg::SD_SETUP_MIN_NS) begin
            timing_err = 1'h1;
         end
         if (ir_tx_input === 1'h1) begin
            ir_up     = 1'h1;
            ir_rise_t = $time;
         end else if (ir_up && ($time - ir_rise_t >= ir_ctl_pkg::RC_PULSE_MIN_NS)) begin
            rc_seen = 1'h1;
         end
      end
      if (fell_once && ($time - sd_fall_t < ir_ctl_pkg::LATCH_HOLD_MIN_NS)) begin
         timing_err = 1'h1;
      end
      ir_chg_t = $time;
   end

   // the falling shutdown edge ends a shutdown, latches a mode, or flags a timing error
   always @(negedge shutdown_in) begin
      if (shutdown_in === 1'h0 && sd_up) begin
         sd_up     = 1'h0;
         fell_once = 1'h1;
         sd_fall_t = $time;
         if ($time - sd_rise_t >= ir_ctl_pkg::SHUTDOWN_PULSE_MIN_US * 1000) begin
            mode = ir_ctl_pkg::MODE_SIR;
         end else if (($time - sd_rise_t > ir_ctl_pkg::PROG_PULSE_MAX_NS) ||
                      ($time - sd_rise_t <= ir_ctl_pkg::SD_SETUP_MIN_NS + ir_ctl_pkg::RC_PULSE_MIN_NS)) begin
            timing_err = 1'h1;
         end else begin
            if ($time - ir_chg_t < ir_ctl_pkg::BW_SETUP_MIN_NS) begin
               timing_err = 1'h1;
            end
            mode = rc_seen ? ir_ctl_pkg::MODE_RC :
                   (ir_tx_input ? ir_ctl_pkg::MODE_FAST : ir_ctl_pkg::MODE_SIR);
         end
      end
   end
endmodule : ir_xcvr_model

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
   logic       core_clk  = 1'h0;
   logic       srst      = 1'h1;
   logic       prog_req  = 1'h0;
   logic       shdn_req  = 1'h0;
   logic       ir_data   = 1'h0;
   logic       rc_data   = 1'h0;
   logic       light     = 1'h1;
   logic [1:0] prog_mode = 2'h0;
   logic [1:0] cur_mode;
   logic [1:0] cur_mode2;
   logic [1:0] mdl_mode;
   logic [1:0] mdl_mode2;
   logic       prog_busy;
   logic       prog_busy2;
   logic       rx_data;
   logic       rx_data2;
   logic       sd1;
   logic       ir1;
   logic       rc1;
   logic       rx1;
   logic       led1;
   logic       err1;
   logic       sd2;
   logic       ir2;
   logic       rc2;
   logic       rx2;
   logic       led2;
   logic       err2;
   int         num_errors = 0;
   int         compares   = 0;

   ir_mode_ctl #(.TWO_PIN(1'h0)) dut_u (
      .core_clk    (core_clk),
      .srst        (srst),
      .prog_req    (prog_req),
      .prog_mode   (prog_mode),
      .prog_busy   (prog_busy),
      .shdn_req    (shdn_req),
      .ir_data     (ir_data),
      .rc_data     (rc_data),
      .cur_mode    (cur_mode),
      .rx_data     (rx_data),
      .shutdown_in (sd1),
      .ir_tx_input (ir1),
      .rc_tx_input (rc1),
      .rx_pin      (rx1)
   );
   ir_xcvr_model model_u (
      .shutdown_in (sd1),
      .ir_tx_input (ir1),
      .rc_tx_input (rc1),
      .light       (light),
      .rx_pin      (rx1),
      .led         (led1),
      .mode        (mdl_mode),
      .timing_err  (err1)
   );
   ir_mode_ctl #(.TWO_PIN(1'h1)) dut2_u (
      .core_clk    (core_clk),
      .srst        (srst),
      .prog_req    (prog_req),
      .prog_mode   (prog_mode),
      .prog_busy   (prog_busy2),
      .shdn_req    (shdn_req),
      .ir_data     (ir_data),
      .rc_data     (rc_data),
      .cur_mode    (cur_mode2),
      .rx_data     (rx_data2),
      .shutdown_in (sd2),
      .ir_tx_input (ir2),
      .rc_tx_input (rc2),
      .rx_pin      (rx2)
   );
   ir_xcvr_model model2_u (
      .shutdown_in (sd2),
      .ir_tx_input (ir2),
      .rc_tx_input (rc2),
      .light       (light),
      .rx_pin      (rx2),
      .led         (led2),
      .mode        (mdl_mode2),
      .timing_err  (err2)
   );

   task chk(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task test_done;
      if (num_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task t_reset;
      chk(cur_mode, ir_ctl_pkg::MODE_SIR);
      chk(mdl_mode, ir_ctl_pkg::MODE_SIR);
      chk(prog_busy, 1'h0);
   endtask : t_reset

   // no handshake on the direct pins, so settle a few cycles
   task t_two_pin(input logic ir, input logic rc, input logic lt);
      @(negedge core_clk);
      ir_data = ir;
      rc_data = rc;
      light   = lt;
      repeat (4) @(negedge core_clk);
      chk({ir2, rc2}, {ir && !rc, rc && !ir});
      chk(led2, ir ^ rc);
      chk(rx_data2, lt);
      chk(rx_data, lt);
   endtask : t_two_pin

   task t_program(input logic [1:0] m);
      @(negedge core_clk);
      prog_req  = 1'h1;
      prog_mode = m;
      @(negedge core_clk);
      prog_req = 1'h0;
      chk(prog_busy, 1'h1);
      chk(prog_busy2, 1'h0);
      for (int i = 0; i < 200 && prog_busy; i++) @(negedge core_clk);
      chk(prog_busy, 1'h0);
      chk(cur_mode, m);
      chk(mdl_mode, m);
      chk(err1, 1'h0);
   endtask : t_program

   task t_single_tx(input logic ir, input logic rc, input logic exp);
      @(negedge core_clk);
      ir_data = ir;
      rc_data = rc;
      repeat (4) @(negedge core_clk);
      chk(led1, exp);
      ir_data = 1'h0;
      rc_data = 1'h0;
      repeat (4) @(negedge core_clk);
   endtask : t_single_tx

   task t_shutdown;
      @(negedge core_clk);
      shdn_req = 1'h1;
      light    = 1'h0;
      repeat (10) @(negedge core_clk);
      chk(sd1, 1'h1);
      chk(led1, 1'h0);
      chk(rx_data, 1'h1);
      shdn_req = 1'h0;
      repeat (3730) @(negedge core_clk);
      chk(sd1, 1'h1);
      for (int i = 0; i < 100 && prog_busy; i++) @(negedge core_clk);
      chk(prog_busy, 1'h0);
      chk(cur_mode, ir_ctl_pkg::MODE_SIR);
      chk(mdl_mode, ir_ctl_pkg::MODE_SIR);
      chk(mdl_mode2, ir_ctl_pkg::MODE_SIR);
      chk(err1, 1'h0);
      chk(err2, 1'h0);
      light = 1'h1;
      repeat (10) @(negedge core_clk);
   endtask : t_shutdown

   initial forever #4 core_clk = ~core_clk;

   initial begin
      repeat (20) @(negedge core_clk);
      srst = 1'h0;
      repeat (2) @(negedge core_clk);
      t_reset();
      t_two_pin(1'h0, 1'h0, 1'h0);
      t_two_pin(1'h1, 1'h0, 1'h1);
      t_two_pin(1'h0, 1'h1, 1'h0);
      t_two_pin(1'h1, 1'h1, 1'h1);
      t_two_pin(1'h0, 1'h0, 1'h1);
      t_program(ir_ctl_pkg::MODE_RC);
      t_single_tx(1'h0, 1'h1, 1'h1);
      t_single_tx(1'h1, 1'h0, 1'h0);
      t_program(ir_ctl_pkg::MODE_FAST);
      t_single_tx(1'h1, 1'h0, 1'h1);
      t_single_tx(1'h0, 1'h1, 1'h0);
      repeat (20) @(negedge core_clk);
      chk(cur_mode, ir_ctl_pkg::MODE_FAST);
      t_shutdown();
      t_single_tx(1'h1, 1'h0, 1'h1);
      t_program(ir_ctl_pkg::MODE_SIR);
      test_done();
   end

   initial begin
      #200000;
      num_errors++;
      test_done();
   end
endmodule : testbench

/* File: hdl/ir_ctl_pkg.sv */
package ir_ctl_pkg;
   localparam int CLK_PERIOD_NS = 8;
   // timing figures in their own units
   localparam int SHUTDOWN_PULSE_MIN_US = 30;
   localparam int SD_SETUP_MIN_NS       = 200;
   localparam int RC_PULSE_MIN_NS       = 200;
   localparam int PROG_PULSE_MAX_NS     = 5000;
   localparam int BW_SETUP_MIN_NS       = 50;
   localparam int LATCH_HOLD_MIN_NS     = 50;
   // least times round up, longest round down
   localparam int SHUTDOWN_CYC = (SHUTDOWN_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC    = (SD_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_CYC       = (RC_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_MAX_CYC = PROG_PULSE_MAX_NS / CLK_PERIOD_NS;
   localparam int BW_CYC       = (BW_SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC     = (LATCH_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W        = 13;

   typedef enum logic [1:0] {
      MODE_SIR = 2'h0,
      MODE_FAST = 2'h1,
      MODE_RC = 2'h2
   } ir_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SETUP = 3'h1,
      ST_RCPUL = 3'h3,
      ST_BW    = 3'h2,
      ST_HOLD  = 3'h6,
      ST_SHDN  = 3'h7,
      ST_GAP   = 3'h5
   } prog_state_t;
endpackage : ir_ctl_pkg

/* File: hdl/ir_mode_ctl.sv */
`timescale 1ns/1ns
// Summary of operation
// - program mode by shutdown plus transmit pulse (with TWO_PIN set, prog_req is ignored and no programming runs)
// - shutdown high 30 us means full shutdown
// - programming pulse no longer than 5 us
// - raise shutdown 200 ns before transmit acts
// - 200 ns transmit pulse selects remote drive
// - bandwidth level set 50 ns before latch
// - hold inputs 50 ns after latching edge
// - never drive both transmit inputs high
module ir_mode_ctl #(
   parameter int SHUTDOWN_CYCLES = ir_ctl_pkg::SHUTDOWN_CYC,
   parameter bit TWO_PIN         = 1'b0
) (
   input  wire logic      core_clk,
   input  wire logic      srst,
   input  wire logic      prog_req,
   input  wire logic [1:0] prog_mode,
   output logic           prog_busy,
   input  wire logic      shdn_req,
   input  wire logic      ir_data,
   input  wire logic      rc_data,
   output logic [1:0]     cur_mode,
   output logic           rx_data,
   output logic           shutdown_in,
   output logic           ir_tx_input,
   output logic           rc_tx_input,
   input  wire logic      rx_pin
);
   localparam int CW = ir_ctl_pkg::CNT_W;

   ir_ctl_pkg::prog_state_t state_r;
   ir_ctl_pkg::prog_state_t state_nxt;
   ir_ctl_pkg::ir_mode_t    cur_mode_r;
   ir_ctl_pkg::ir_mode_t    cur_mode_nxt;
   ir_ctl_pkg::ir_mode_t    tgt_mode_r;
   ir_ctl_pkg::ir_mode_t    tgt_mode_nxt;
   logic [CW-1:0]           cnt_r;
   logic [CW-1:0]           cnt_nxt;
   logic [CW-1:0]           sd_prog_cnt_r;
   logic [CW-1:0]           sd_prog_cnt_nxt;
   logic                    sd_r;
   logic                    sd_nxt;
   logic                    ir_r;
   logic                    ir_nxt;
   logic                    rc_r;
   logic                    rc_nxt;
   logic                    rx_sync;
   logic                    setup_done;
   logic                    rc_done;
   logic                    bw_done;
   logic                    hold_done;
   logic                    shdn_done;
   logic                    cnt_full;
   logic                    bw_level;
   logic                    rc_pulse;
   logic                    prog_window;
   logic                    start_prog;
   logic                    single_tx;
   logic                    two_ir;
   logic                    two_rc;

   // true on the last cycle of a phase lasting lim cycles
   function automatic logic cnt_at(input logic [CW-1:0] cnt, input int lim);
      cnt_at = (cnt == CW'(lim - 1));
   endfunction : cnt_at

   // an unknown request code falls back to the slow mode
   function automatic ir_ctl_pkg::ir_mode_t legal_mode(input logic [1:0] m);
      if (m == ir_ctl_pkg::MODE_FAST) begin
         legal_mode = ir_ctl_pkg::MODE_FAST;
      end else if (m == ir_ctl_pkg::MODE_RC) begin
         legal_mode = ir_ctl_pkg::MODE_RC;
      end else begin
         legal_mode = ir_ctl_pkg::MODE_SIR;
      end
   endfunction : legal_mode

   ir_sync2 sync_u (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (rx_pin),
      .q        (rx_sync)
   );

   // phase ends, all counted in whole clocks rounded up
   assign setup_done = cnt_at(cnt_r, ir_ctl_pkg::SETUP_CYC);
   assign rc_done    = cnt_at(cnt_r, ir_ctl_pkg::RC_CYC);
   assign bw_done    = cnt_at(cnt_r, ir_ctl_pkg::BW_CYC);
   assign hold_done  = cnt_at(cnt_r, ir_ctl_pkg::HOLD_CYC);
   // shutdown stays up while requested, never shorter than the minimum
   assign shdn_done  = (cnt_r >= CW'(SHUTDOWN_CYCLES - 1)) && !shdn_req;
   assign cnt_full   = &cnt_r;

   assign bw_level    = (tgt_mode_r == ir_ctl_pkg::MODE_FAST);
   assign rc_pulse    = (tgt_mode_r == ir_ctl_pkg::MODE_RC);
   assign start_prog  = prog_req && !TWO_PIN;
   assign prog_window = (state_nxt == ir_ctl_pkg::ST_SETUP) ||
                        (state_nxt == ir_ctl_pkg::ST_RCPUL) ||
                        (state_nxt == ir_ctl_pkg::ST_BW);

   // one pin carries whichever source the latched mode selects
   assign single_tx = (cur_mode_nxt == ir_ctl_pkg::MODE_RC) ? rc_data : ir_data;
   // both high would leave the device dark, so neither is sent
   assign two_ir    = ir_data && !rc_data;
   assign two_rc    = rc_data && !ir_data;

   assign cnt_nxt         = (state_nxt != state_r) ? '0 : (cnt_full ? cnt_r : cnt_r + CW'(1));
   assign sd_prog_cnt_nxt = prog_window ? sd_prog_cnt_r + CW'(1) : '0;

   assign tgt_mode_nxt = (state_r == ir_ctl_pkg::ST_IDLE && state_nxt == ir_ctl_pkg::ST_SETUP) ?
                         legal_mode(prog_mode) : tgt_mode_r;

   assign cur_mode_nxt = (state_r == ir_ctl_pkg::ST_SHDN) ? ir_ctl_pkg::MODE_SIR :
                         (state_r == ir_ctl_pkg::ST_HOLD && hold_done) ? tgt_mode_r :
                         cur_mode_r;

   assign prog_busy   = (state_r != ir_ctl_pkg::ST_IDLE);
   assign cur_mode    = cur_mode_r;
   assign shutdown_in = sd_r;
   assign ir_tx_input = ir_r;
   assign rc_tx_input = rc_r;
   assign rx_data     = rx_sync;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ir_ctl_pkg::ST_IDLE: begin
            // shutdown wins over a programming request
            if (shdn_req) begin
               state_nxt = ir_ctl_pkg::ST_SHDN;
            end else if (start_prog) begin
               state_nxt = ir_ctl_pkg::ST_SETUP;
            end
         end
         ir_ctl_pkg::ST_SETUP: begin
            if (setup_done) begin
               state_nxt = ir_ctl_pkg::ST_RCPUL;
            end
         end
         ir_ctl_pkg::ST_RCPUL: begin
            if (rc_done) begin
               state_nxt = ir_ctl_pkg::ST_BW;
            end
         end
         ir_ctl_pkg::ST_BW: begin
            if (bw_done) begin
               state_nxt = ir_ctl_pkg::ST_HOLD;
            end
         end
         ir_ctl_pkg::ST_HOLD: begin
            if (hold_done) begin
               state_nxt = ir_ctl_pkg::ST_IDLE;
            end
         end
         ir_ctl_pkg::ST_SHDN: begin
            if (shdn_done) begin
               state_nxt = ir_ctl_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = ir_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   // pins follow the next state so they line up with state_r
   always_comb begin
      sd_nxt = 1'h0;
      ir_nxt = 1'h0;
      rc_nxt = 1'h0;
      unique case (state_nxt)
         ir_ctl_pkg::ST_SETUP: begin
            sd_nxt = 1'h1;
         end
         ir_ctl_pkg::ST_RCPUL: begin
            sd_nxt = 1'h1;
            ir_nxt = rc_pulse;
         end
         ir_ctl_pkg::ST_BW: begin
            sd_nxt = 1'h1;
            ir_nxt = bw_level;
         end
         ir_ctl_pkg::ST_HOLD: begin
            ir_nxt = bw_level;
         end
         ir_ctl_pkg::ST_SHDN: begin
            sd_nxt = 1'h1;
         end
         ir_ctl_pkg::ST_IDLE: begin
            if (TWO_PIN) begin
               ir_nxt = two_ir;
               rc_nxt = two_rc;
            end else begin
               ir_nxt = single_tx;
            end
         end
         default: begin
            sd_nxt = 1'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r    <= ir_ctl_pkg::ST_IDLE;
         cur_mode_r <= ir_ctl_pkg::MODE_SIR;
         tgt_mode_r <= ir_ctl_pkg::MODE_SIR;
      end else begin
         state_r    <= state_nxt;
         cur_mode_r <= cur_mode_nxt;
         tgt_mode_r <= tgt_mode_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_r         <= '0;
         sd_prog_cnt_r <= '0;
      end else begin
         cnt_r         <= cnt_nxt;
         sd_prog_cnt_r <= sd_prog_cnt_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sd_r <= 1'h0;
         ir_r <= 1'h0;
         rc_r <= 1'h0;
      end else begin
         sd_r <= sd_nxt;
         ir_r <= ir_nxt;
         rc_r <= rc_nxt;
      end
   end

   a_reset_slow_mode: assert property (
      @(posedge core_clk) srst |=> cur_mode_r == ir_ctl_pkg::MODE_SIR
   ) else $error("mode not slow after reset");

   a_setup_quiet: assert property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_SETUP |-> sd_r && !ir_r
   ) else $error("transmit moved during shutdown setup");

   a_rc_pulse_drive: assert property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_RCPUL |-> sd_r && (ir_r == rc_pulse)
   ) else $error("remote pulse phase drives wrong level");

   a_bw_stable: assert property (
      @(posedge core_clk) disable iff (srst)
      (state_r == ir_ctl_pkg::ST_BW && $past(state_r) == ir_ctl_pkg::ST_BW) |-> sd_r && $stable(ir_r)
   ) else $error("bandwidth level moved before latch");

   a_latch_hold: assert property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_HOLD |-> !sd_r && $stable(ir_r)
   ) else $error("transmit moved inside hold time");

   a_prog_pulse_max: assert property (
      @(posedge core_clk) disable iff (srst)
      sd_prog_cnt_r <= CW'(ir_ctl_pkg::PROG_MAX_CYC)
   ) else $error("programming pulse too long");

   a_prog_pulse_min: assert property (
      @(posedge core_clk) disable iff (srst)
      (state_r == ir_ctl_pkg::ST_BW && bw_done) |-> sd_prog_cnt_r > CW'(ir_ctl_pkg::SETUP_CYC + ir_ctl_pkg::RC_CYC)
   ) else $error("programming pulse too short");

   a_shutdown_drive: assert property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_SHDN |-> sd_r && !ir_r && !rc_r
   ) else $error("shutdown pins wrong");

   a_shutdown_min: assert property (
      @(posedge core_clk) disable iff (srst)
      (state_r == ir_ctl_pkg::ST_SHDN && state_nxt == ir_ctl_pkg::ST_IDLE) |-> cnt_r >= CW'(SHUTDOWN_CYCLES - 1)
   ) else $error("shutdown pulse too short");

   a_shutdown_default: assert property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_SHDN |=> cur_mode_r == ir_ctl_pkg::MODE_SIR
   ) else $error("shutdown kept a programmed mode");

   a_two_pin_excl: assert property (
      @(posedge core_clk) disable iff (srst)
      !(ir_r && rc_r)
   ) else $error("both transmit pins high");

   a_single_pin_only: assert property (
      @(posedge core_clk) disable iff (srst)
      !TWO_PIN |-> !rc_r
   ) else $error("remote pin used in single pin operation");

   a_two_pin_follow: assert property (
      @(posedge core_clk) disable iff (srst)
      (TWO_PIN && state_r == ir_ctl_pkg::ST_IDLE && !$past(srst)) |->
         (ir_r == $past(two_ir)) && (rc_r == $past(two_rc))
   ) else $error("two pin drive does not follow data");

   a_mode_hold: assert property (
      @(posedge core_clk) disable iff (srst)
      (state_r != ir_ctl_pkg::ST_SHDN && state_r != ir_ctl_pkg::ST_HOLD) |=> $stable(cur_mode_r)
   ) else $error("mode changed without programming");

   c_rc_latched: cover property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_HOLD && tgt_mode_r == ir_ctl_pkg::MODE_RC
   );

   c_fast_latched: cover property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_HOLD && tgt_mode_r == ir_ctl_pkg::MODE_FAST
   );

   c_shutdown_done: cover property (
      @(posedge core_clk) disable iff (srst)
      state_r == ir_ctl_pkg::ST_SHDN ##1 state_r == ir_ctl_pkg::ST_IDLE
   );

   c_two_pin_remote: cover property (
      @(posedge core_clk) disable iff (srst)
      TWO_PIN && rc_r
   );
endmodule : ir_mode_ctl

/* File: hdl/ir_sync2.sv */
`timescale 1ns/1ns
module ir_sync2 (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic d,
   output logic      q
);
   logic meta_r;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : ir_sync2
